// ==== hw/buck_pkg.sv ====
package buck_pkg;

    // =========================================================
    // clock and switching timing
    // =========================================================
    localparam int CLK_HZ            = 20_000_000;
    localparam int CLK_NS            = 50;
    localparam int SWITCH_HZ         = 275_000;
    // one switching period in logic clocks, rounded down to whole clocks
    localparam int PERIOD_CYC        = CLK_HZ / SWITCH_HZ;
    localparam int DUTY_MAX_PCT      = 82;
    // longest high-side time rounds down, so duty never passes the ceiling
    localparam int MAX_ON_CYC        = PERIOD_CYC * DUTY_MAX_PCT / 100;
    localparam int MIN_PULSE_NS      = 100;
    // shortest pulse rounds up to whole clocks
    localparam int MIN_ON_CYC        = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // dead time between one gate falling and the other rising
    localparam int DEAD_NS           = 50;
    localparam int DEAD_CYC          = (DEAD_NS + CLK_NS - 1) / CLK_NS;

    // =========================================================
    // overcurrent protection
    // =========================================================
    localparam int TRIP_LIMIT        = 7;
    localparam int OC_SET_US         = 3000;
    // whole setting procedure, cut into equal ramp steps
    localparam int OC_SET_CYC        = OC_SET_US * (CLK_HZ / 1_000_000);
    localparam int OC_MIN_MV         = 50;
    localparam int OC_MAX_MV         = 450;
    localparam int OC_STEP_MV        = 10;
    localparam int OC_STEPS          = (OC_MAX_MV - OC_MIN_MV) / OC_STEP_MV + 1;
    localparam int OC_STEP_CYC       = OC_SET_CYC / OC_STEPS;
    localparam int OC_CODE_W         = 6;
    localparam logic [OC_CODE_W-1:0] OC_CODE_DEFAULT = 6'h3f;
    localparam int OC_DEFAULT_MV     = 96;

    // =========================================================
    // carriers
    // =========================================================
    // synchronised comparator results
    typedef struct packed {
        logic vcc_ok;       // control supply above lockout threshold
        logic boot_ok;      // bootstrap supply above threshold
        logic comp_enable;  // loop filter node above enable level
        logic comp_disable; // loop filter node below disable level
        logic fb_reached;   // feedback_input at reference level
        logic oc_trip;      // switch_node below trip level
        logic ramp_met;     // stepped ramp reached low_gate_pin
        logic clamp_hit;    // low_gate_pin clamp fired
        logic pwm_cmp;      // loop comparator: end the on-time
    } sense_t;

    typedef enum logic [2:0] {
        ST_LOCKOUT  = 3'b000,
        ST_OC_SET   = 3'b001,
        ST_CHARGE   = 3'b011,
        ST_SWITCH   = 3'b010,
        ST_DISABLED = 3'b110,
        ST_LATCHED  = 3'b111
    } seq_t;

    typedef enum logic [1:0] {
        PH_LOW  = 2'b00,
        PH_DEAD = 2'b01,
        PH_HIGH = 2'b11,
        PH_DHL  = 2'b10
    } phase_t;

endpackage

// ==== hw/buck_pwm_sequencer_protect.sv ====
`timescale 1ns/1ps
module buck_pwm_sequencer_protect
    import buck_pkg::*;
#(
    parameter int OC_SET_CYCLES = OC_SET_CYC,
    parameter int PERIOD_CYCLES = PERIOD_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // analog comparator results
    input  wire sense_t               sense_in,
    // gate drivers and switch node
    output logic                      high_gate,
    output logic                      low_gate,
    output logic                      switch_node_float,
    // analog support controls
    output logic                      soft_start_charge,
    output logic                      soft_start_discharge,
    output logic                      error_amp_low_source,
    output logic                      error_amp_regulating,
    output logic                      limit_set_current,
    output logic [OC_CODE_W-1:0]      ramp_step,
    output logic [OC_CODE_W-1:0]      oc_code,
    // status
    output logic                      enabled,
    output logic                      oc_latched
);

    localparam int STEP_CYC = OC_SET_CYCLES / OC_STEPS;
    // longest pulse follows the period actually in use, rounded down
    localparam int MAX_ON   = PERIOD_CYCLES * DUTY_MAX_PCT / 100;
    // one width serves the period, on-time and step counters
    localparam int CNT_W    = $clog2(PERIOD_CYCLES + STEP_CYC + 1);

    // =========================================================
    // parameter checks
    // =========================================================
    if (MAX_ON <= MIN_ON_CYC + 2 * DEAD_CYC) begin : g_bad_period
        $error("switching period too short for pulse limits");
    end
    // the period must leave a forced low interval after the longest pulse and both dead times
    if (MAX_ON + 2 * DEAD_CYC >= PERIOD_CYCLES) begin : g_no_off_time
        $error("no room for the forced off interval");
    end
    // ramp_met arrives two clocks late, so a step needs three clocks
    if (STEP_CYC < 3) begin : g_short_step
        $error("threshold setting time too short");
    end
    if (OC_STEPS >= (1 << OC_CODE_W)) begin : g_narrow_code
        $error("threshold code too narrow");
    end

    // =========================================================
    // state
    // =========================================================
    // whole block state in one register, updated once per clock
    typedef struct packed {
        sense_t                  sync1;
        sense_t                  sync2;
        seq_t                    seq;
        phase_t                  phase;
        logic [CNT_W-1:0]        period_cnt;
        logic [CNT_W-1:0]        on_cnt;
        logic [CNT_W-1:0]        step_cnt;
        logic [2:0]              trips;
        logic                    regulating;
        logic                    hg;
        logic                    lg;
        logic                    flt;
        logic                    ss_chg;
        logic                    ss_dis;
        logic                    low_src;
        logic                    iset;
        logic [OC_CODE_W-1:0]    step;
        logic [OC_CODE_W-1:0]    code;
        logic                    en;
        logic                    latched;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    function automatic logic [CNT_W-1:0] cnt_of(input int v);
        return CNT_W'(v);
    endfunction

    // synchronised view of the comparators, the only one logic reads
    sense_t s;
    logic   period_end;
    logic   on_done;
    logic   sample_pt;

    // =========================================================
    // decode
    // =========================================================
    always_comb begin
        s          = st_r.sync2;
        period_end = (st_r.period_cnt ==
                      cnt_of(PERIOD_CYCLES - 1));
        // on-time ends on the loop comparator once the minimum is served,
        // or at the ceiling regardless of the loop
        on_done    = ((st_r.on_cnt >= cnt_of(MIN_ON_CYC - 1))
                      && s.pwm_cmp)
                   || (st_r.on_cnt >= cnt_of(MAX_ON - 1));
        // last low-side clock before the dead time that precedes high side
        sample_pt  = (st_r.phase == PH_LOW) && period_end;
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        st_nxt       = st_r;
        // plain two-stage synchroniser, first stage read by nothing else
        st_nxt.sync1 = sense_in;
        st_nxt.sync2 = st_r.sync1;

        // free-running, so the period does not drift across mode changes
        st_nxt.period_cnt = period_end ? '0 : st_r.period_cnt + cnt_of(1);

        case (st_r.seq)
        ST_LOCKOUT: begin
            // everything off, soft-start drained, node floating
            st_nxt.hg      = 1'b0;
            st_nxt.lg      = 1'b0;
            st_nxt.flt     = 1'b1;
            st_nxt.ss_chg  = 1'b0;
            st_nxt.ss_dis  = 1'b1;
            st_nxt.en      = 1'b0;
            st_nxt.latched = 1'b0;
            st_nxt.trips   = '0;
            st_nxt.regulating = 1'b0;
            st_nxt.phase   = PH_LOW;
            if (s.vcc_ok) begin
                st_nxt.seq      = ST_OC_SET;
                st_nxt.iset     = 1'b1;
                // ramp restarts from the lowest step at every power-up
                st_nxt.step     = '0;
                st_nxt.step_cnt = '0;
            end
        end
        ST_OC_SET: begin
            // counts clocks within the current ramp step
            st_nxt.step_cnt = st_r.step_cnt + cnt_of(1);
            if (s.clamp_hit) begin
                // open or oversized set resistor: fall back at once
                st_nxt.code = OC_CODE_DEFAULT;
                st_nxt.iset = 1'b0;
                st_nxt.seq  = ST_CHARGE;
            end else if (st_r.step_cnt == cnt_of(STEP_CYC - 1)) begin
                // compare only late in the step so the ramp has settled
                st_nxt.step_cnt = '0;
                if (s.ramp_met ||
                    st_r.step == OC_CODE_W'(OC_STEPS - 1)) begin
                    st_nxt.code = st_r.step;
                    st_nxt.iset = 1'b0;
                    st_nxt.seq  = ST_CHARGE;
                end else begin
                    st_nxt.step = st_r.step + OC_CODE_W'(1);
                end
            end
        end
        ST_CHARGE: begin
            st_nxt.ss_dis  = 1'b0;
            // source current waits for both supplies, the state does not
            st_nxt.ss_chg  = s.boot_ok && s.vcc_ok;
            st_nxt.low_src = 1'b0;
            if (s.comp_enable) begin
                st_nxt.seq   = ST_SWITCH;
                st_nxt.flt   = 1'b0;
                st_nxt.en    = 1'b1;
                st_nxt.phase = PH_LOW;
                st_nxt.lg    = 1'b1;
            end
        end
        ST_SWITCH: begin
            // regulation mode is sticky until disable or lockout
            st_nxt.regulating = st_r.regulating | s.fb_reached;
            case (st_r.phase)
            PH_LOW: begin
                st_nxt.lg = 1'b1;
                if (period_end) begin
                    st_nxt.lg    = 1'b0;
                    st_nxt.phase = PH_DEAD;
                end
            end
            PH_DEAD: begin
                // high side only after low gate has gone down
                if (!st_r.lg) begin
                    st_nxt.hg     = 1'b1;
                    st_nxt.on_cnt = '0;
                    st_nxt.phase  = PH_HIGH;
                end
            end
            PH_HIGH: begin
                // on_cnt is zero on the first high clock
                st_nxt.on_cnt = st_r.on_cnt + cnt_of(1);
                if (on_done) begin
                    st_nxt.hg    = 1'b0;
                    st_nxt.phase = PH_DHL;
                end
            end
            PH_DHL: begin
                // low side waits one clock after the high gate drops
                if (!st_r.hg) begin
                    st_nxt.lg    = 1'b1;
                    st_nxt.phase = PH_LOW;
                end
            end
            default: st_nxt.phase = PH_LOW;
            endcase
            // one sample per period, on the last low-side clock
            if (sample_pt) begin
                if (s.oc_trip) begin
                    st_nxt.trips = st_r.trips + 3'h1;
                end else begin
                    st_nxt.trips = '0;
                end
            end
            if (sample_pt && s.oc_trip &&
                st_r.trips == 3'(TRIP_LIMIT - 1)) begin
                // also covers soft-start: trips override the ramp-up
                st_nxt.seq     = ST_LATCHED;
                st_nxt.hg      = 1'b0;
                st_nxt.lg      = 1'b0;
                st_nxt.flt     = 1'b1;
                st_nxt.ss_chg  = 1'b0;
                st_nxt.en      = 1'b0;
                st_nxt.latched = 1'b1;
            end else if (s.comp_disable) begin
                st_nxt.seq     = ST_DISABLED;
                st_nxt.hg      = 1'b0;
                st_nxt.lg      = 1'b1;
                st_nxt.en      = 1'b0;
                st_nxt.low_src = 1'b1;
                st_nxt.phase   = PH_LOW;
            end
        end
        ST_DISABLED: begin
            // held low side on; waits for the node to climb past enable
            st_nxt.hg      = 1'b0;
            st_nxt.lg      = 1'b1;
            st_nxt.low_src = 1'b1;
            st_nxt.regulating = 1'b0;
            if (s.comp_enable) begin
                st_nxt.seq     = ST_SWITCH;
                st_nxt.en      = 1'b1;
                st_nxt.low_src = 1'b0;
                st_nxt.phase   = PH_LOW;
                // a fresh enable starts a fresh trip count
                st_nxt.trips   = '0;
            end
        end
        ST_LATCHED: begin
            // only a supply drop releases the latch
            st_nxt.hg = 1'b0;
            st_nxt.lg = 1'b0;
        end
        default: st_nxt.seq = ST_LOCKOUT;
        endcase

        // supply loss wins over every other state
        if (!s.vcc_ok && st_r.seq != ST_LOCKOUT) begin
            st_nxt.seq     = ST_LOCKOUT;
            st_nxt.hg      = 1'b0;
            st_nxt.lg      = 1'b0;
            st_nxt.flt     = 1'b1;
            st_nxt.ss_chg  = 1'b0;
            st_nxt.ss_dis  = 1'b1;
            st_nxt.iset    = 1'b0;
            st_nxt.en      = 1'b0;
            st_nxt.trips   = '0;
            st_nxt.regulating = 1'b0;
        end
        // final guard: never both gates on
        if (st_nxt.hg) begin
            st_nxt.lg = 1'b0;
        end
    end

    // =========================================================
    // register
    // =========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r         <= '0;
            st_r.seq     <= ST_LOCKOUT;
            st_r.phase   <= PH_LOW;
            st_r.flt     <= 1'b1;
            st_r.ss_dis  <= 1'b1;
            st_r.low_src <= 1'b1;
            st_r.code    <= OC_CODE_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    // every output is a register bit, nothing after the flops
    assign high_gate            = st_r.hg;
    assign low_gate             = st_r.lg;
    assign switch_node_float    = st_r.flt;
    assign soft_start_charge    = st_r.ss_chg;
    assign soft_start_discharge = st_r.ss_dis;
    assign error_amp_low_source = st_r.low_src;
    assign error_amp_regulating = st_r.regulating;
    assign limit_set_current    = st_r.iset;
    assign ramp_step            = st_r.step;
    assign oc_code              = st_r.code;
    assign enabled              = st_r.en;
    assign oc_latched           = st_r.latched;

endmodule

// ==== testbench/buck_asserts.sv ====
`timescale 1ns/1ps
module buck_asserts
    import buck_pkg::*;
#(
    parameter int OC_SET_CYCLES = OC_SET_CYC,
    parameter int PERIOD_CYCLES = PERIOD_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // comparator results
    input  wire sense_t               sense_in,
    // gate drive
    input  wire logic                 high_gate,
    input  wire logic                 low_gate,
    input  wire logic                 switch_node_float,
    // analog support
    input  wire logic                 soft_start_charge,
    input  wire logic                 soft_start_discharge,
    input  wire logic                 error_amp_low_source,
    input  wire logic                 error_amp_regulating,
    input  wire logic                 limit_set_current,
    input  wire logic [OC_CODE_W-1:0] ramp_step,
    input  wire logic [OC_CODE_W-1:0] oc_code,
    // status
    input  wire logic                 enabled,
    input  wire logic                 oc_latched
);
    // =========================================================
    // run-length counters
    // =========================================================
    logic [15:0] hi_r;
    logic [15:0] gap_r;
    logic [15:0] set_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_r  <= '0;
            gap_r <= '0;
            set_r <= '0;
        end else begin
            hi_r  <= high_gate ? hi_r + 16'h0001 : '0;
            gap_r <= (low_gate || !enabled) ? '0 : gap_r + 16'h0001;
            set_r <= limit_set_current ? set_r + 16'h0001 : '0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // =========================================================
    // properties
    // =========================================================
    a_no_overlap: assert property (!(high_gate && low_gate))
        else $error("both gates on");
    a_dead_time: assert property (
        $rose(high_gate) |-> !$past(low_gate))
        else $error("high gate rose without dead time");
    a_min_pulse: assert property ($rose(high_gate) |=> high_gate)
        else $error("high pulse below minimum");
    a_max_pulse: assert property (high_gate |-> hi_r < MAX_ON_CYC)
        else $error("high pulse above ceiling");
    // off-time of one dead clock each side plus the longest pulse
    a_off_each: assert property (gap_r <= MAX_ON_CYC + 2)
        else $error("no low side interval in period");
    a_set_bound: assert property (set_r < OC_SET_CYCLES + 2)
        else $error("threshold setting too long");
    a_float_quiet: assert property (switch_node_float |->
        !high_gate && !low_gate && !enabled)
        else $error("float with gate driven");
    a_latched_off: assert property (oc_latched |->
        !high_gate && !low_gate && switch_node_float)
        else $error("latched but gate driven");
    a_latch_holds: assert property (
        oc_latched && sense_in.vcc_ok |=> oc_latched)
        else $error("latch released without lockout");
    a_lockout_stop: assert property ((!sense_in.vcc_ok)[*5] |->
        soft_start_discharge && switch_node_float && !high_gate
        && !low_gate)
        else $error("lockout outputs wrong");
    a_code_range: assert property (oc_code <= 6'h28 ||
        oc_code == OC_CODE_DEFAULT)
        else $error("threshold code out of range");
    c_enable: cover property ($rose(enabled));
    c_latch: cover property ($rose(oc_latched));
    c_regulate: cover property ($rose(error_amp_regulating));
endmodule

bind buck_pwm_sequencer_protect buck_asserts #(
    .OC_SET_CYCLES(OC_SET_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .sense_in(sense_in), .high_gate(high_gate),
    .low_gate(low_gate), .switch_node_float(switch_node_float),
    .soft_start_charge(soft_start_charge),
    .soft_start_discharge(soft_start_discharge),
    .error_amp_low_source(error_amp_low_source),
    .error_amp_regulating(error_amp_regulating),
    .limit_set_current(limit_set_current), .ramp_step(ramp_step),
    .oc_code(oc_code), .enabled(enabled), .oc_latched(oc_latched)
);

// ==== testbench/buck_analog_model.sv ====
`timescale 1ns/1ps
module buck_analog_model
    import buck_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // design side
    input  wire logic                 high_gate,
    input  wire logic                 low_gate,
    input  wire logic                 soft_start_charge,
    input  wire logic                 soft_start_discharge,
    input  wire logic                 limit_set_current,
    input  wire logic [OC_CODE_W-1:0] ramp_step,
    // analog conditions set by the bench
    input  wire logic [6:0]           cond,
    input  wire logic [OC_CODE_W-1:0] set_level,
    // comparator results
    output sense_t                    sense_out
);
    // =========================================================
    // loop filter node, 10 mV per clock
    // =========================================================
    int comp_mv = 0;
    // cond: vcc, boot, pull, fb, clamp, short, cmp
    always_ff @(posedge clk) begin
        // outside pull only ever sinks the node
        if (soft_start_discharge || cond[4]) begin
            comp_mv <= 0;
        end else if (soft_start_charge && comp_mv < 1000) begin
            comp_mv <= comp_mv + 10;
        end
    end
    always_comb begin
        sense_out.vcc_ok       = cond[6];
        sense_out.boot_ok      = cond[5];
        sense_out.comp_enable  = comp_mv > 830;
        sense_out.comp_disable = comp_mv < 400;
        sense_out.fb_reached   = cond[3];
        // node only falls below trip while the low side conducts
        sense_out.oc_trip      = cond[1] && low_gate;
        sense_out.ramp_met     = limit_set_current && ramp_step >= set_level;
        sense_out.clamp_hit    = limit_set_current && cond[2];
        sense_out.pwm_cmp      = cond[0];
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
`define WAITC(c, m) begin for (int k = 0; k < (m) && !(c); k++) step(1); \
    if (!(c)) begin miscompares++; print_verdict(); end end
module tb_top
    import buck_pkg::*;
;
    localparam int SETC = 820;
    localparam int PER  = 72;
    typedef struct { logic cmp; int width; } row_t;
    logic                 clk, rst, hg, lg, flt, chg, dis, lsrc, reg_on;
    logic                 iset, en, latched;
    logic                 vcc_on, boot_on, pull_low, fb_on, clamp_on;
    logic                 short_on, cmp_on;
    logic [OC_CODE_W-1:0] rstep, oc_code, set_level;
    sense_t               sense_in;
    int                   miscompares, compares, n, w, p;
    row_t                 rows [2] = '{'{1'b1, MIN_ON_CYC}, '{1'b0, MAX_ON_CYC}};

    buck_pwm_sequencer_protect #(.OC_SET_CYCLES(SETC), .PERIOD_CYCLES(PER))
    uut (.clk(clk), .rst(rst), .sense_in(sense_in), .high_gate(hg),
        .low_gate(lg), .switch_node_float(flt), .soft_start_charge(chg),
        .soft_start_discharge(dis), .error_amp_low_source(lsrc),
        .error_amp_regulating(reg_on), .limit_set_current(iset),
        .ramp_step(rstep), .oc_code(oc_code), .enabled(en),
        .oc_latched(latched));
    buck_analog_model model (.clk(clk), .high_gate(hg), .low_gate(lg),
        .soft_start_charge(chg), .soft_start_discharge(dis),
        .limit_set_current(iset), .ramp_step(rstep), .set_level(set_level),
        .cond({vcc_on, boot_on, pull_low, fb_on, clamp_on, short_on, cmp_on}),
        .sense_out(sense_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // =========================================================
    // helpers: every input moves 5 ns after a rising edge
    // =========================================================
    task automatic step(input int c);
        repeat (c) begin
            @(posedge clk);
            #5;
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic measure();
        `WAITC(!hg, 200)
        `WAITC(hg, 200)
        for (w = 0; hg && w < 100; w++) step(1);
        for (p = w; !hg && p < 200; p++) step(1);
    endtask
    task automatic count_set();
        `WAITC(iset, 8)
        for (n = 0; iset && n < SETC + 50; n++) step(1);
    endtask
    // =========================================================
    // sequence
    // =========================================================
    initial begin
        {vcc_on, boot_on, pull_low, fb_on, clamp_on, short_on, cmp_on} = '0;
        set_level = 6'h0c;
        miscompares = 0;
        compares = 0;
        rst = 1'b1;
        step(8);
        rst = 1'b0;
        `CHK("reset", 6'h0e, {hg, lg, flt, dis, lsrc, chg})
        `CHK("code_rst", OC_CODE_DEFAULT, oc_code)
        vcc_on = 1'b1;
        count_set();
        `CHK("set_time", 1'b1, n <= SETC)
        `CHK("oc_code", 6'h0c, oc_code)
        `CHK("ramp_step", 6'h0c, rstep)
        step(20);
        `CHK("no_charge", 1'b0, chg)
        boot_on = 1'b1;
        `WAITC(chg, 8)
        step(40);
        `CHK("still_float", 2'b10, {flt, en})
        `WAITC(en, 200)
        `CHK("enable", 2'b01, {flt, lg})
        for (int i = 0; i < 2; i++) begin
            cmp_on = rows[i].cmp;
            measure();
            measure();
            `CHK("width", rows[i].width, w)
            `CHK("period", PER, p)
        end
        fb_on = 1'b1;
        step(6);
        `CHK("regulate", 1'b1, reg_on)
        // broken run of trips must restart the count
        short_on = 1'b1;
        step(4 * PER);
        short_on = 1'b0;
        step(2 * PER);
        `CHK("no_latch", 1'b0, latched)
        short_on = 1'b1;
        for (n = 0; !latched && n < 10 * PER; n++) step(1);
        `CHK("trip_count", 1'b1, n > 5 * PER && n < 8 * PER)
        `CHK("trip_off", 3'b001, {hg, lg, flt})
        short_on = 1'b0;
        step(3 * PER);
        `CHK("latched", 1'b1, latched)
        vcc_on = 1'b0;
        step(5);
        `CHK("lockout", 5'b11000, {dis, flt, hg, lg, latched})
        clamp_on = 1'b1;
        vcc_on = 1'b1;
        count_set();
        `CHK("clamp_end", 1'b1, n <= 6)
        `CHK("clamp_code", OC_CODE_DEFAULT, oc_code)
        clamp_on = 1'b0;
        `WAITC(en, 300)
        pull_low = 1'b1;
        step(6);
        `CHK("disable", 4'b0110, {hg, lg, lsrc, en})
        print_verdict();
    end
endmodule
